// ===== logic/xmp_cfg.svh
// constants for the mac-side xmii port: offsets, fields, resets, codes
// Operation
// [RULE1] control multiplexed on one line, both edges
// [RULE2] parallel clocks run at 125 MHz
// [RULE3] mac data: control high then low
// [RULE4] high/high error, low/low idle, low/high reserved
// [RULE5] device sends low/low between frames
// [RULE6] device sends high/low with received nibbles
// [RULE7] device sends high/high on errored data
// [RULE8] low/high with 1110 marks false carrier
// [RULE9] idle nibble carries link and duplex status
// [RULE10] serial mode uses one pair each way
// [RULE11] serial mode carries no clock; receivers recover
// [RULE12] serial config bit 0 low disables autoneg
// [RULE13] low nibble rising edge, high nibble falling
`ifndef XMP_CFG_SVH
`define XMP_CFG_SVH

// register byte addresses
`define XMP_ADDR_W        12
`define XMP_OFF_CTRL      12'h600
`define XMP_OFF_STAT      12'h604
`define XMP_OFF_SER_CFG   12'h608

// control register fields
`define XMP_CTRL_SER_SEL  0
`define XMP_CTRL_LINK     1
`define XMP_CTRL_DUPLEX   2
`define XMP_CTRL_W        3
`define XMP_CTRL_RST      3'h0

// serial interface configuration register
`define XMP_SER_CFG_W     16
`define XMP_SER_ANEG      0
`define XMP_SER_CFG_RST   16'h0001

// status register fields, each an 8-bit counter
`define XMP_CNT_W         8
`define XMP_STAT_FRM_LSB  0
`define XMP_STAT_ERR_LSB  8
`define XMP_STAT_RSV_LSB  16

// line codes
`define XMP_NIB_FALSE_CAR 4'hE
`define XMP_LINK_CLK_MHZ  125

`endif

// ===== logic/xmp_pkg.sv
// types shared by the mac-side xmii port
package xmp_pkg;

  // one link clock cycle of a double-edge lane: control and data per edge
  typedef struct packed {
    logic       ctl_r;
    logic       ctl_f;
    logic [3:0] d_r;
    logic [3:0] d_f;
  } xmp_ddr_t;

  // one byte toward or from the line-side coding logic
  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } xmp_byte_t;

  // transmit frame tracker
  typedef enum logic [0:0] {
    XMP_TX_IDLE,
    XMP_TX_FRAME
  } xmp_tx_state_t;

endpackage

// ===== logic/xmp_sync.sv
// two-flop level synchroniser, one stage pair per bit
module xmp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // first stage is read by the second stage only
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_reg;
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        meta_reg <= 1'b0;
        q[i]     <= 1'b0;
      end else begin
        meta_reg <= d[i];
        q[i]     <= meta_reg;
      end
    end
  end

endmodule

// ===== logic/xmp_port.sv
// mac-side xmii port: double-edge parallel lanes, serial select, apb regs
`include "xmp_cfg.svh"

module xmp_port
  import xmp_pkg::*;
(
  // register side, core clock
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`XMP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // mode outputs toward the serial lane logic
  output logic                        serial_sel,
  output logic                        serial_aneg_en,
  // link side, clocked by the transmit clock from the mac
  input  wire logic                   link_clk,
  input  wire xmp_ddr_t               rgmii_tx,
  output logic                        rgmii_rx_clk,
  output xmp_ddr_t                    rgmii_rx,
  output xmp_byte_t                   pcs_tx,
  input  wire xmp_byte_t              pcs_rx,
  input  wire logic                   pcs_false_carrier
);

  // ---------------------------------------------------------------
  // core clock domain: registers
  // ---------------------------------------------------------------
  logic [`XMP_CTRL_W-1:0]    ctrl_reg;
  logic [`XMP_SER_CFG_W-1:0] ser_cfg_reg;
  logic [`XMP_CNT_W-1:0]     frm_cnt_reg;
  logic [`XMP_CNT_W-1:0]     err_cnt_reg;
  logic [`XMP_CNT_W-1:0]     rsv_cnt_reg;
  logic                      pready_reg;
  logic [31:0]               prdata_reg;
  logic                      pslverr_reg;
  logic                      access;
  logic                      wr_fire;
  logic                      hit_ctrl;
  logic                      hit_stat;
  logic                      hit_ser;
  logic                      hit_any;
  logic [31:0]               rd_mux;

  // address decode; unmapped addresses answer with an error
  assign hit_ctrl = (paddr == `XMP_OFF_CTRL);
  assign hit_stat = (paddr == `XMP_OFF_STAT);
  assign hit_ser  = (paddr == `XMP_OFF_SER_CFG);
  assign hit_any  = hit_ctrl | hit_stat | hit_ser;
  assign access   = psel & penable;
  assign wr_fire  = access & pready_reg & pwrite;

  // read mux, unused bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[`XMP_CTRL_W-1:0] = ctrl_reg;
    end else if (hit_ser) begin
      rd_mux[`XMP_SER_CFG_W-1:0] = ser_cfg_reg;
    end else if (hit_stat) begin
      rd_mux[`XMP_STAT_FRM_LSB +: `XMP_CNT_W] = frm_cnt_reg;
      rd_mux[`XMP_STAT_ERR_LSB +: `XMP_CNT_W] = err_cnt_reg;
      rd_mux[`XMP_STAT_RSV_LSB +: `XMP_CNT_W] = rsv_cnt_reg;
    end
  end

  // one wait state keeps read data registered; ready drops after use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (access && !pready_reg) begin
      pready_reg  <= 1'b1;
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= ~hit_any;
    end else begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // control register: mode select and the in-band status levels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `XMP_CTRL_RST;
    end else if (wr_fire && hit_ctrl && pstrb[0]) begin
      ctrl_reg <= pwdata[`XMP_CTRL_W-1:0];
    end
  end

  // serial configuration, written per byte lane
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ser_cfg_reg <= `XMP_SER_CFG_RST;
    end else if (wr_fire && hit_ser) begin
      if (pstrb[0]) begin
        ser_cfg_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        ser_cfg_reg[15:8] <= pwdata[15:8];
      end
    end
  end

  // serial lane mode; autoneg follows bit 0 of the serial config
  assign serial_sel     = ctrl_reg[`XMP_CTRL_SER_SEL]; // RULE10
  assign serial_aneg_en = ser_cfg_reg[`XMP_SER_ANEG];  // RULE12

  // ---------------------------------------------------------------
  // crossings
  // ---------------------------------------------------------------
  logic [2:0] cfg_link;    // {duplex, link, serial} in link domain
  logic [2:0] tgl_link;    // event toggles from the link domain
  logic [2:0] tgl_core;
  logic [2:0] tgl_seen_reg;
  logic [2:0] ev_core;

  // static levels into the link domain; a change lands two edges later
  xmp_sync #(.W(3)) u_cfg_sync (
    .clk  (link_clk),
    .rstn (rstn),
    .d    ({ctrl_reg[`XMP_CTRL_DUPLEX], ctrl_reg[`XMP_CTRL_LINK],
            ctrl_reg[`XMP_CTRL_SER_SEL]}),
    .q    (cfg_link)
  );

  // toggles carry one event each; events closer than a few core
  // cycles apart on the same toggle would merge, which frames prevent
  xmp_sync #(.W(3)) u_evt_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (tgl_link),
    .q    (tgl_core)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tgl_seen_reg <= 3'h0;
    end else begin
      tgl_seen_reg <= tgl_core;
    end
  end

  assign ev_core = tgl_core ^ tgl_seen_reg;

  // status counters wrap; software takes differences
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frm_cnt_reg <= 8'h00;
      err_cnt_reg <= 8'h00;
      rsv_cnt_reg <= 8'h00;
    end else begin
      if (ev_core[0]) begin
        frm_cnt_reg <= frm_cnt_reg + 8'h01;
      end
      if (ev_core[1]) begin
        err_cnt_reg <= err_cnt_reg + 8'h01;
      end
      if (ev_core[2]) begin
        rsv_cnt_reg <= rsv_cnt_reg + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // link clock domain: transmit decode from the mac
  // ---------------------------------------------------------------
  logic          ser_link;
  logic          link_up;
  logic          full_dup;
  xmp_tx_state_t tx_state_reg;
  logic          tx_err_seen_reg;
  logic [2:0]    tgl_reg;
  logic [1:0]    tx_code;
  logic          tx_active;

  assign ser_link = cfg_link[0];
  assign link_up  = cfg_link[1];
  assign full_dup = cfg_link[2];

  // both edge samples of the control line form one code
  assign tx_code   = {rgmii_tx.ctl_r, rgmii_tx.ctl_f}; // RULE1
  assign tx_active = rgmii_tx.ctl_r & ~ser_link;

  // byte out to the line side; low nibble came on the rising edge
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      pcs_tx <= '0;
    end else begin
      pcs_tx.valid <= tx_active;                        // RULE3
      pcs_tx.err   <= tx_active & rgmii_tx.ctl_f;       // RULE4
      pcs_tx.data  <= {rgmii_tx.d_f, rgmii_tx.d_r};     // RULE13
    end
  end

  // frame tracker: a frame ends when the mac returns to inter-frame
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_reg    <= XMP_TX_IDLE;
      tx_err_seen_reg <= 1'b0;
    end else begin
      case (tx_state_reg)
        XMP_TX_IDLE: begin
          tx_err_seen_reg <= 1'b0;
          if (tx_active) begin
            tx_state_reg    <= XMP_TX_FRAME;
            tx_err_seen_reg <= rgmii_tx.ctl_f;
          end
        end
        XMP_TX_FRAME: begin
          if (!tx_active) begin
            tx_state_reg <= XMP_TX_IDLE;
          end else if (rgmii_tx.ctl_f) begin
            tx_err_seen_reg <= 1'b1; // RULE4
          end
        end
        default: begin
          tx_state_reg    <= XMP_TX_IDLE;
          tx_err_seen_reg <= 1'b0;
        end
      endcase
    end
  end

  // event toggles: frame done, errored frame done, reserved code seen
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      tgl_reg <= 3'h0;
    end else begin
      if (tx_state_reg == XMP_TX_FRAME && !tx_active) begin
        tgl_reg[0] <= ~tgl_reg[0];
        if (tx_err_seen_reg) begin
          tgl_reg[1] <= ~tgl_reg[1];
        end
      end
      // the low-then-high code is ignored as data, only counted
      if (!ser_link && tx_code == 2'b01) begin
        tgl_reg[2] <= ~tgl_reg[2]; // RULE4
      end
    end
  end

  assign tgl_link = tgl_reg;

  // ---------------------------------------------------------------
  // link clock domain: receive encode toward the mac
  // ---------------------------------------------------------------
  logic [3:0] status_nib;

  // in-band status: duplex on bit 3, link on bit 0
  assign status_nib = {full_dup, 2'b00, link_up}; // RULE9

  // receive clock is the link clock forwarded, 125 MHz at gigabit;
  // in serial mode the mac recovers its clock from the lane instead
  assign rgmii_rx_clk = link_clk & ~ser_link; // RULE2 RULE11

  // encode priority: error, data, false carrier, inter-frame
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      rgmii_rx <= '0;
    end else if (ser_link) begin
      rgmii_rx <= '0; // RULE10
    end else if (pcs_rx.valid && pcs_rx.err) begin
      rgmii_rx.ctl_r <= 1'b1; // RULE7
      rgmii_rx.ctl_f <= 1'b1;
      rgmii_rx.d_r   <= pcs_rx.data[3:0];
      rgmii_rx.d_f   <= pcs_rx.data[7:4];
    end else if (pcs_rx.valid) begin
      rgmii_rx.ctl_r <= 1'b1; // RULE6
      rgmii_rx.ctl_f <= 1'b0;
      rgmii_rx.d_r   <= pcs_rx.data[3:0]; // RULE13
      rgmii_rx.d_f   <= pcs_rx.data[7:4];
    end else if (pcs_false_carrier) begin
      rgmii_rx.ctl_r <= 1'b0; // RULE8
      rgmii_rx.ctl_f <= 1'b1;
      rgmii_rx.d_r   <= `XMP_NIB_FALSE_CAR;
      rgmii_rx.d_f   <= `XMP_NIB_FALSE_CAR;
    end else begin
      rgmii_rx.ctl_r <= 1'b0; // RULE5
      rgmii_rx.ctl_f <= 1'b0;
      rgmii_rx.d_r   <= status_nib; // RULE9
      rgmii_rx.d_f   <= status_nib;
    end
  end

endmodule

// ===== dv/xmp_port_props.sv
// assertions on the ports of the mac-side xmii port
module xmp_port_props
  import xmp_pkg::*;
(
  input wire logic      clk,
  input wire logic      rstn,
  input wire logic      psel,
  input wire logic      penable,
  input wire logic      pready,
  input wire logic      pslverr,
  input wire logic      serial_sel,
  input wire logic      link_clk,
  input wire xmp_ddr_t  rgmii_tx,
  input wire xmp_ddr_t  rgmii_rx,
  input wire xmp_byte_t pcs_tx,
  input wire xmp_byte_t pcs_rx,
  input wire logic      pcs_false_carrier
);
  // setup cycle then the first access cycle
  sequence acc_s;
    psel && !penable ##1 psel && penable;
  endsequence
  // parallel mode held long enough to have crossed into the link domain
  sequence par_s;
    !serial_sel [*4];
  endsequence

  apb_wait_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_s |-> !pready ##1 pready) else $error("apb wait state wrong");
  ready_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    pready |=> !pready) else $error("pready too long");
  err_ready_a: assert property (@(posedge clk) disable iff (!rstn)
    pslverr |-> pready) else $error("pslverr without pready");
  tx_data_a: assert property (@(posedge link_clk) disable iff (!rstn)
    par_s ##0 rgmii_tx.ctl_r |=> pcs_tx.valid
    && pcs_tx.err == $past(rgmii_tx.ctl_f)
    && pcs_tx.data == $past({rgmii_tx.d_f, rgmii_tx.d_r}))
    else $error("tx byte wrong");
  tx_gap_a: assert property (@(posedge link_clk) disable iff (!rstn)
    !rgmii_tx.ctl_r |=> !pcs_tx.valid) else $error("tx byte in gap");
  rx_data_a: assert property (@(posedge link_clk) disable iff (!rstn)
    par_s ##0 pcs_rx.valid |=> rgmii_rx.ctl_r
    && rgmii_rx.ctl_f == $past(pcs_rx.err)
    && {rgmii_rx.d_f, rgmii_rx.d_r} == $past(pcs_rx.data))
    else $error("rx byte wrong");
  rx_false_a: assert property (@(posedge link_clk) disable iff (!rstn)
    par_s ##0 !pcs_rx.valid && pcs_false_carrier |=> rgmii_rx == 10'h1EE)
    else $error("false carrier code wrong");
  rx_idle_a: assert property (@(posedge link_clk) disable iff (!rstn)
    par_s ##0 !pcs_rx.valid && !pcs_false_carrier |=> !rgmii_rx.ctl_r
    && !rgmii_rx.ctl_f && rgmii_rx.d_r[2:1] == 2'h0)
    else $error("rx idle code wrong");
  serial_quiet_a: assert property (@(posedge link_clk) disable iff (!rstn)
    serial_sel [*6] |-> rgmii_rx == 10'h000 && !pcs_tx.valid)
    else $error("parallel lanes active in serial mode");
endmodule

// ===== dv/xmp_mac_model.sv
// mac model: forwards the transmit clock and drives the tx lanes
module xmp_mac_model
  import xmp_pkg::*;
(
  output logic     link_clk,
  output xmp_ddr_t rgmii_tx
);
  timeunit 1ns;
  timeprecision 100ps;
  // free running, as the in-band status needs the clock between frames
  initial begin
    link_clk = 1'b0;
    forever #7.5 link_clk = ~link_clk;
  end
  initial rgmii_tx = '0;
  // one byte: ctl high on rise, err flag on fall, low nibble first
  task automatic send(input logic [7:0] b, input logic e);
    @(posedge link_clk);
    rgmii_tx <= {1'b1, e, b[3:0], b[7:4]};
  endtask
  // gap: data lines keep changing; rsv gives the reserved code on demand
  task automatic gap(input logic rsv);
    @(posedge link_clk);
    rgmii_tx <= {1'b0, rsv, 4'($urandom), 4'($urandom)};
  endtask
endmodule

// ===== dv/testbench.sv
// testbench for the mac-side xmii port with a reference model
`define CHK(a, x) begin num_checks++; if ((a) !== (x)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, x); end end

module testbench
  import xmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, q;
  logic        serial_sel, serial_aneg_en, link_clk, rgmii_rx_clk;
  logic        pcs_false_carrier, chk, lnk, dup;
  xmp_ddr_t    rgmii_tx, rgmii_rx, erx;
  xmp_byte_t   pcs_tx, pcs_rx, etx;
  int          error_cnt, num_checks;

  xmp_port xmp_port_i (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .serial_sel,
    .serial_aneg_en, .link_clk, .rgmii_tx, .rgmii_rx_clk, .rgmii_rx,
    .pcs_tx, .pcs_rx, .pcs_false_carrier);
  xmp_mac_model xmp_mac_model_i (.link_clk, .rgmii_tx);

  // core clock, 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one apb transfer, request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 40) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
    `CHK(e, xe)
  endtask

  // reference: check last edge's prediction, then predict the next one
  always @(posedge link_clk) begin
    if (chk) begin
      `CHK(pcs_tx.valid, etx.valid)
      if (etx.valid)
        `CHK(pcs_tx, etx)
      `CHK(rgmii_rx, erx)
    end
    etx = {rgmii_tx.ctl_r, rgmii_tx.ctl_f, rgmii_tx.d_f, rgmii_tx.d_r};
    if (pcs_rx.valid)
      erx = {1'b1, pcs_rx.err, pcs_rx.data[3:0], pcs_rx.data[7:4]};
    else if (pcs_false_carrier)
      erx = {2'b01, 8'hEE};
    else
      erx = {2'b00, dup, 2'b00, lnk, dup, 2'b00, lnk};
  end

  // registers, both link directions, serial switch-over and back
  initial begin
    int v;
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    {pcs_rx, pcs_false_carrier, chk, lnk, dup} = '0;
    {error_cnt, num_checks} = '0;
    void'($urandom(99));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(12'h600, 32'h0, 1'b0);
    rd(12'h608, 32'h1, 1'b0);
    rd(12'h700, 32'h0, 1'b1);
    apb(1'b1, 12'h608, 32'h0);
    rd(12'h608, 32'h0, 1'b0);
    `CHK(serial_aneg_en, 1'b0)
    // lanes without a strobe keep their bits; the status word is read-only
    pstrb <= 4'h2;
    apb(1'b1, 12'h608, 32'h0000_AB01);
    apb(1'b1, 12'h600, 32'h7);
    rd(12'h608, 32'h0000_AB00, 1'b0);
    rd(12'h600, 32'h0, 1'b0);
    pstrb <= 4'hF;
    apb(1'b1, 12'h604, 32'hFFFF_FFFF);
    rd(12'h604, 32'h0, 1'b0);
    apb(1'b1, 12'h600, 32'h6);
    {lnk, dup} = 2'b11;
    repeat (8) @(posedge link_clk);
    chk = 1'b1;
    fork
      begin
        repeat (6) xmp_mac_model_i.send(8'($urandom), 1'b0);
        xmp_mac_model_i.gap(1'b0);
        xmp_mac_model_i.send(8'($urandom), 1'b0);
        xmp_mac_model_i.send(8'($urandom), 1'b1);
        xmp_mac_model_i.gap(1'b0);
        xmp_mac_model_i.gap(1'b1);
        repeat (3) xmp_mac_model_i.gap(1'b0);
      end
      for (int i = 0; i < 40; i++) begin
        @(posedge link_clk);
        v = $urandom;
        pcs_rx <= {v[0], v[1], v[9:2]};
        pcs_false_carrier <= v[10];
      end
    join
    repeat (20) @(posedge clk);
    rd(12'h604, 32'h0001_0102, 1'b0);
    chk = 1'b0;
    apb(1'b1, 12'h600, 32'h1);
    repeat (6) @(posedge link_clk);
    // a reserved code while the serial lane is selected must not count
    xmp_mac_model_i.gap(1'b1);
    xmp_mac_model_i.send(8'h5A, 1'b0);
    pcs_rx <= {1'b1, 1'b0, 8'h3C};
    repeat (2) @(posedge link_clk);
    `CHK(serial_sel, 1'b1)
    `CHK(pcs_tx.valid, 1'b0)
    `CHK(rgmii_rx, 10'h000)
    #1 `CHK(rgmii_rx_clk, 1'b0)
    pcs_rx <= '0;
    apb(1'b1, 12'h600, 32'h6);
    repeat (8) @(posedge link_clk);
    chk = 1'b1;
    #1 `CHK(rgmii_rx_clk, 1'b1)
    repeat (3) xmp_mac_model_i.send(8'($urandom), 1'b0);
    repeat (4) xmp_mac_model_i.gap(1'b0);
    // the held byte resumes as one frame; serial-mode codes left no count
    repeat (20) @(posedge clk);
    rd(12'h604, 32'h0001_0103, 1'b0);
    finish_test();
  end
endmodule

bind xmp_port xmp_port_props xmp_port_props_i (.clk, .rstn, .psel,
  .penable, .pready, .pslverr, .serial_sel, .link_clk, .rgmii_tx,
  .rgmii_rx, .pcs_tx, .pcs_rx, .pcs_false_carrier);
